// ---- src/bmb_unit.sv ----
// execution unit for single-bit instructions and program flow.
// assumes decode supplies resolved operands, a byte/word memory port that
// acknowledges with a one-cycle i_mem_ack, and a same-clock register port.
`default_nettype none

module bmb_unit (
    input wire logic i_clk,                      // 50 MHz core clock
    input wire logic i_resetn,                   // synchronous reset, active low
    input wire logic i_cmd_valid,                // instruction offered
    input wire bmb_pkg::bmb_cmd_t i_cmd,         // decoded instruction
    output logic o_ready,                        // unit idle, takes i_cmd
    output bmb_pkg::bmb_resp_t o_resp,           // completion
    output bmb_pkg::bmb_mem_req_t o_mem,         // memory request
    input wire logic i_mem_ack,                  // memory access finished
    input wire logic [31:0] i_mem_rdata,         // read data with ack
    output logic [3:0] o_flags,                  // condition flags
    input wire logic [1:0] i_reg_addr,           // software register index
    input wire logic [31:0] i_reg_wdata,         // software write data
    input wire logic i_reg_wr,                   // software write strobe
    input wire logic i_reg_rd,                   // software read strobe
    output logic [31:0] o_reg_rdata              // read data, cycle after strobe
);

    bmb_pkg::bmb_state_t q; // registered state
    bmb_pkg::bmb_state_t d; // next state

    // register work ends in the take cycle
    // memory and stack work walks read/write
    // states; each request is held to its ack
    // hazard: memory data stand only with ack,
    // so the byte is used then and never kept
    // limitation: one instruction at a time
    // condition evaluation: even codes take the branch when the term is 0
    function automatic logic cond_true(input logic [3:0] cc, input logic [3:0] f);
        logic x;
        x = 1'b0;
        // odd codes branch on a set term
        unique case (cc[3:1])
            3'h0: x = 1'b0; // always / never
            3'h1: x = f[bmb_pkg::FLG_C] | f[bmb_pkg::FLG_Z];
            3'h2: x = f[bmb_pkg::FLG_C];
            3'h3: x = f[bmb_pkg::FLG_Z];
            3'h4: x = f[bmb_pkg::FLG_V];
            3'h5: x = f[bmb_pkg::FLG_N];
            3'h6: x = f[bmb_pkg::FLG_N] ^ f[bmb_pkg::FLG_V];
            3'h7: x = f[bmb_pkg::FLG_Z] | (f[bmb_pkg::FLG_N] ^ f[bmb_pkg::FLG_V]);
        endcase
        return x ^ ~cc[0];
    endfunction

    // software writes share this process so
    // the flags keep a single driver
    // trade-off: results are computed each
    // cycle from the live operand; one path
    // serves register and memory operands
    // next-state logic: register port, then the instruction sequencer
    always_comb begin
        bmb_pkg::bmb_cmd_t c;
        logic [7:0] opnd;
        logic [2:0] pos;
        logic bv;
        logic cy;
        logic [7:0] nbyte;
        logic [3:0] nflg;
        logic wback;
        c = (q.st == bmb_pkg::st_idle) ? i_cmd : q.cmd;
        opnd = '0;
        pos = '0;
        bv = 1'b0;
        cy = 1'b0;
        nbyte = '0;
        nflg = '0;
        wback = 1'b0;
        d = q;
        d.resp.done = 1'b0;
        d.resp.reg_we = 1'b0;
        d.resp.pc_load = 1'b0;

        // software writes first, so a flag update by an instruction below wins
        if (i_reg_wr) begin
            if (i_reg_addr == bmb_pkg::REG_FLAGS) begin
                d.flags = i_reg_wdata[3:0];
            end else if (i_reg_addr == bmb_pkg::REG_SP) begin
                d.sp = i_reg_wdata;
            end
        end
        // read data stand only in the cycle after the strobe
        d.rdata = '0;
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                bmb_pkg::REG_FLAGS: d.rdata = {28'h0, q.flags};
                bmb_pkg::REG_SP: d.rdata = q.sp;
                bmb_pkg::REG_STATUS: begin
                    d.rdata[bmb_pkg::STS_BUSY] = ~q.ready;
                    d.rdata[bmb_pkg::STS_TAKEN] = q.taken;
                end
                default: d.rdata = '0; // unmapped index reads zero
            endcase
        end

        // memory byte is valid in the ack cycle
        // byte operand: the register byte, or the low byte read from memory
        opnd = (q.st == bmb_pkg::st_idle) ? c.reg_data : i_mem_rdata[7:0];
        // only set/clear/invert/test may take the bit number from a register
        if (c.bit_from_reg && c.op inside {bmb_pkg::bit_set_op, bmb_pkg::bit_clear_op,
                bmb_pkg::bit_invert_op, bmb_pkg::bit_test_op}) begin
            pos = c.bit_reg[2:0];
        end else begin
            pos = c.bit_imm;
        end
        bv = opnd[pos];
        cy = d.flags[bmb_pkg::FLG_C];
        nbyte = opnd;
        nflg = d.flags;
        // result of every bit operation
        unique case (c.op)
            bmb_pkg::bit_set_op: begin
                nbyte[pos] = 1'b1;
                wback = 1'b1;
            end
            bmb_pkg::bit_clear_op: begin
                nbyte[pos] = 1'b0;
                wback = 1'b1;
            end
            bmb_pkg::bit_invert_op: begin
                nbyte[pos] = ~bv;
                wback = 1'b1;
            end
            bmb_pkg::bit_test_op: nflg[bmb_pkg::FLG_Z] = ~bv;
            bmb_pkg::carry_and_bit_op: nflg[bmb_pkg::FLG_C] = cy & bv;
            bmb_pkg::carry_and_inv_bit_op: nflg[bmb_pkg::FLG_C] = cy & ~bv;
            bmb_pkg::carry_or_bit_op: nflg[bmb_pkg::FLG_C] = cy | bv;
            bmb_pkg::carry_or_inv_bit_op: nflg[bmb_pkg::FLG_C] = cy | ~bv;
            bmb_pkg::carry_xor_bit_op: nflg[bmb_pkg::FLG_C] = cy ^ bv;
            bmb_pkg::carry_xor_inv_bit_op: nflg[bmb_pkg::FLG_C] = cy ^ ~bv;
            bmb_pkg::bit_to_carry_op: nflg[bmb_pkg::FLG_C] = bv;
            bmb_pkg::inv_bit_to_carry_op: nflg[bmb_pkg::FLG_C] = ~bv;
            bmb_pkg::carry_to_bit_op: begin
                nbyte[pos] = cy;
                wback = 1'b1;
            end
            bmb_pkg::inv_carry_to_bit_op: begin
                nbyte[pos] = ~cy;
                wback = 1'b1;
            end
            default: wback = 1'b0; // flow instructions touch no operand
        endcase

        // idle takes, read and write wait
        unique case (q.st)
            bmb_pkg::st_idle: begin
                if (i_cmd_valid && q.ready) begin
                    d.cmd = i_cmd;
                    unique case (i_cmd.op)
                        bmb_pkg::cond_branch_op: begin
                            // kept for the status register
                            d.taken = cond_true(i_cmd.cond, d.flags);
                            d.resp.pc_load = d.taken;
                            d.resp.pc = i_cmd.target;
                            d.resp.done = 1'b1;
                        end
                        bmb_pkg::unconditional_jump_op: begin
                            // no stack access
                            d.resp.pc_load = 1'b1;
                            d.resp.pc = i_cmd.target;
                            d.resp.done = 1'b1;
                        end
                        bmb_pkg::relative_call_op, bmb_pkg::absolute_call_op: begin
                            // push return address as one word below sp
                            d.mem.wr = 1'b1;
                            d.mem.word = 1'b1;
                            d.mem.addr = d.sp - bmb_pkg::STACK_STEP;
                            d.mem.wdata = i_cmd.pc_next;
                            d.st = bmb_pkg::st_write;
                            d.ready = 1'b0;
                        end
                        bmb_pkg::return_op: begin
                            // sp moves after the ack
                            d.mem.rd = 1'b1;
                            d.mem.word = 1'b1;
                            d.mem.addr = d.sp;
                            d.st = bmb_pkg::st_read;
                            d.ready = 1'b0;
                        end
                        default: begin
                            // bit ops on a register end now
                            if (i_cmd.mem_op) begin
                                // memory operand: fetch one byte first
                                d.mem.rd = 1'b1;
                                d.mem.word = 1'b0;
                                d.mem.addr = i_cmd.addr;
                                d.st = bmb_pkg::st_read;
                                d.ready = 1'b0;
                            end else begin
                                d.flags = nflg;
                                d.resp.reg_we = wback;
                                d.resp.reg_data = nbyte;
                                d.resp.done = 1'b1;
                            end
                        end
                    endcase
                end
            end
            bmb_pkg::st_read: begin
                // operand or return address arrives
                if (i_mem_ack) begin
                    d.mem.rd = 1'b0;
                    if (q.cmd.op == bmb_pkg::return_op) begin
                        d.resp.pc_load = 1'b1;
                        d.resp.pc = i_mem_rdata;
                        d.sp = d.sp + bmb_pkg::STACK_STEP;
                        d.resp.done = 1'b1;
                        d.st = bmb_pkg::st_idle;
                        d.ready = 1'b1;
                    end else begin
                        d.flags = nflg;
                        if (wback) begin
                            // read-modify-write of the same byte location
                            d.mem.wr = 1'b1;
                            d.mem.wdata = {24'h0, nbyte};
                            d.st = bmb_pkg::st_write;
                        end else begin
                            d.resp.done = 1'b1;
                            d.st = bmb_pkg::st_idle;
                            d.ready = 1'b1;
                        end
                    end
                end
            end
            bmb_pkg::st_write: begin
                // store or push in flight
                if (i_mem_ack) begin
                    d.mem.wr = 1'b0;
                    if (q.cmd.op == bmb_pkg::relative_call_op) begin
                        d.resp.pc_load = 1'b1;
                        d.resp.pc = q.cmd.pc_next + q.cmd.target;
                        d.sp = d.sp - bmb_pkg::STACK_STEP;
                    end else if (q.cmd.op == bmb_pkg::absolute_call_op) begin
                        d.resp.pc_load = 1'b1;
                        d.resp.pc = q.cmd.target;
                        d.sp = d.sp - bmb_pkg::STACK_STEP;
                    end
                    d.resp.done = 1'b1;
                    d.st = bmb_pkg::st_idle;
                    d.ready = 1'b1;
                end
            end
            default: begin
                d.st = bmb_pkg::st_idle; // unused state code recovers
                d.ready = 1'b1;
            end
        endcase
    end

    // reset drops a half-done bus request;
    // the bus must not hold an ack across it
    // state register; the idle state has code zero
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            // constants only
            q <= '0;
            q.flags <= bmb_pkg::FLAGS_RESET;
            q.sp <= bmb_pkg::SP_RESET;
            q.ready <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // outputs are state fields, never gates
    assign o_ready = q.ready;
    assign o_resp = q.resp;
    assign o_mem = q.mem;
    assign o_flags = q.flags;
    assign o_reg_rdata = q.rdata;

endmodule

`default_nettype wire

// ---- src/bmb_pkg.sv ----
// package for the bit-manipulation and branch execution unit:
// opcodes, command, memory and result carriers, register map, state.
// assumes one clock domain and a decoder that resolves operands first.
`default_nettype none

package bmb_pkg;

    // software register map (word index on the 2-bit register address)
    localparam logic [1:0] REG_FLAGS = 2'h0;    // condition flags, read/write
    localparam logic [1:0] REG_SP = 2'h1;       // stack pointer, read/write
    localparam logic [1:0] REG_STATUS = 2'h2;   // unit status, read only

    // flag bit positions inside the flags register
    localparam int FLG_C = 0;
    localparam int FLG_V = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_N = 3;

    // status bit positions
    localparam int STS_BUSY = 0;
    localparam int STS_TAKEN = 1;

    // reset values and stack step (one 32-bit word per return address)
    localparam logic [3:0] FLAGS_RESET = 4'h0;
    localparam logic [31:0] SP_RESET = 32'h0000_fff0;
    localparam logic [31:0] STACK_STEP = 32'h0000_0004;

    // operations carried out by this unit
    typedef enum logic [4:0] {
        bit_set_op,
        bit_clear_op,
        bit_invert_op,
        bit_test_op,
        carry_and_bit_op,
        carry_and_inv_bit_op,
        carry_or_bit_op,
        carry_or_inv_bit_op,
        carry_xor_bit_op,
        carry_xor_inv_bit_op,
        bit_to_carry_op,
        inv_bit_to_carry_op,
        carry_to_bit_op,
        inv_carry_to_bit_op,
        cond_branch_op,
        unconditional_jump_op,
        relative_call_op,
        absolute_call_op,
        return_op
    } bmb_op_t;

    // one decoded instruction
    typedef struct packed {
        bmb_op_t op;             // operation
        logic mem_op;            // operand in memory at addr, else reg_data
        logic bit_from_reg;      // bit number from bit_reg (set/clear/invert/test only)
        logic [2:0] bit_imm;     // immediate bit number
        logic [7:0] bit_reg;     // register holding bit number (low three bits used)
        logic [7:0] reg_data;    // register byte operand
        logic [31:0] addr;       // memory operand address
        logic [3:0] cond;        // branch condition code
        logic [31:0] target;     // absolute target, or displacement for relative call
        logic [31:0] pc_next;    // address of the following instruction
    } bmb_cmd_t;

    // memory bus request, held until acknowledged
    typedef struct packed {
        logic rd;
        logic wr;
        logic word;              // 1: 32-bit stack access, 0: byte
        logic [31:0] addr;
        logic [31:0] wdata;
    } bmb_mem_req_t;

    // completion of an instruction
    typedef struct packed {
        logic done;              // one-cycle pulse
        logic reg_we;            // write reg_data back to the operand register
        logic [7:0] reg_data;
        logic pc_load;           // load program counter with pc
        logic [31:0] pc;
    } bmb_resp_t;

    typedef enum logic [1:0] {
        st_idle,
        st_read,
        st_write
    } bmb_st_t;

    // whole state of the unit
    typedef struct packed {
        bmb_st_t st;
        bmb_cmd_t cmd;
        logic [3:0] flags;
        logic [31:0] sp;
        bmb_mem_req_t mem;
        bmb_resp_t resp;
        logic ready;
        logic taken;
        logic [31:0] rdata;
    } bmb_state_t;

endpackage

`default_nettype wire

// ---- bench/bmb_mem_model.sv ----
// memory bus model: byte operands and stack words, prompt or slow ack
// assumes rd/wr stay up until the cycle after the one-cycle ack
`default_nettype none
module bmb_mem_model (
    input wire logic i_clk, // core clock
    input wire logic i_resetn, // sync reset, low
    input wire bmb_pkg::bmb_mem_req_t i_mem, // request
    input wire logic i_slow, // four wait cycles
    output logic o_ack, // one-cycle ack
    output logic [31:0] o_rdata // valid with ack only
);
    logic [7:0] mem_b [0:256-1]; // byte operands
    logic [31:0] mem_w [0:256-1]; // stack words by low address byte
    logic [2:0] wait_q; // waits spent on this request
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem_b[i] = 8'(i * 37) ^ 8'h5a;
            mem_w[i] = 32'h0;
        end
    end
    // one ack per request; data toggles when idle so stale values never match
    always @(posedge i_clk) begin
        o_rdata <= i_resetn ? ~o_rdata : 32'h5a5a_a5a5;
        if (!i_resetn || o_ack || !(i_mem.rd || i_mem.wr)) begin
            o_ack <= 1'b0;
            wait_q <= 3'h0;
        end else if (wait_q >= (i_slow ? 3'h4 : 3'h0)) begin
            o_ack <= 1'b1;
            if (i_mem.wr && i_mem.word) mem_w[i_mem.addr[7:0]] <= i_mem.wdata;
            if (i_mem.wr && !i_mem.word) mem_b[i_mem.addr[7:0]] <= i_mem.wdata[7:0];
            // upper lanes of a byte read carry junk on purpose
            if (i_mem.rd) o_rdata <= i_mem.word ? mem_w[i_mem.addr[7:0]] :
                {~o_rdata[31:8], mem_b[i_mem.addr[7:0]]};
        end else begin
            wait_q <= wait_q + 3'h1;
        end
    end
endmodule
`default_nettype wire

// ---- bench/bmb_unit_props.sv ----
// port checker for the bit and branch unit
// assumes one clock and the synchronous low reset
`default_nettype none
module bmb_unit_props (
    input wire logic i_clk, // clock
    input wire logic i_resetn, // reset
    input wire logic i_cmd_valid, // offer
    input wire bmb_pkg::bmb_cmd_t i_cmd, // instruction
    input wire logic o_ready, // idle
    input wire bmb_pkg::bmb_resp_t o_resp, // completion
    input wire bmb_pkg::bmb_mem_req_t o_mem, // memory request
    input wire logic i_mem_ack, // ack
    input wire logic [31:0] i_mem_rdata, // read data
    input wire logic [3:0] o_flags, // flags
    input wire logic [1:0] i_reg_addr, // index
    input wire logic [31:0] i_reg_wdata, // write data
    input wire logic i_reg_wr, // write
    input wire logic i_reg_rd, // read
    input wire logic [31:0] o_reg_rdata // read data
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    logic take, rop, sel, sel_imm;
    logic [2:0] pos;
    logic [7:0] term; // branch term per condition pair
    // software flag writes excluded: they would move the carry under us
    assign take = i_cmd_valid && o_ready;
    assign rop = take && !i_cmd.mem_op && !i_reg_wr;
    assign pos = i_cmd.bit_from_reg ? i_cmd.bit_reg[2:0] : i_cmd.bit_imm;
    assign sel = i_cmd.reg_data[pos];
    assign sel_imm = i_cmd.reg_data[i_cmd.bit_imm];
    assign term = {o_flags[2] | (o_flags[3] ^ o_flags[1]), o_flags[3] ^ o_flags[1],
        o_flags[3], o_flags[1], o_flags[2], o_flags[0], o_flags[0] | o_flags[2], 1'b0};
    AST_SET_REG: assert property (rop && i_cmd.op == bmb_pkg::bit_set_op
        |=> o_resp.reg_we && o_resp.reg_data == ($past(i_cmd.reg_data) | (8'h01 << $past(pos))))
        else $error("bit set result wrong");
    AST_CLEAR_REG: assert property (rop && i_cmd.op == bmb_pkg::bit_clear_op
        |=> o_resp.reg_data == ($past(i_cmd.reg_data) & ~(8'h01 << $past(pos))))
        else $error("bit clear result wrong");
    AST_TEST_Z: assert property (rop && i_cmd.op == bmb_pkg::bit_test_op
        |=> o_resp.done && !o_resp.reg_we && o_flags[2] == !$past(sel))
        else $error("bit test zero flag wrong");
    AST_INV_LOAD: assert property (rop && i_cmd.op == bmb_pkg::inv_bit_to_carry_op
        |=> o_flags[0] == !$past(sel_imm)) else $error("inverted load carry wrong");
    AST_AND_C: assert property (rop && i_cmd.op == bmb_pkg::carry_and_bit_op
        |=> o_flags[0] == ($past(o_flags[0]) & $past(sel_imm))) else $error("carry and wrong");
    AST_BRANCH: assert property (rop && i_cmd.op == bmb_pkg::cond_branch_op
        |=> o_resp.done && o_resp.pc_load == $past(term[i_cmd.cond[3:1]] == i_cmd.cond[0]))
        else $error("branch decision wrong");
    AST_CALL_PUSH: assert property (take && i_cmd.op inside {bmb_pkg::relative_call_op,
        bmb_pkg::absolute_call_op} |=> o_mem.wr && o_mem.word && !o_ready
        && o_mem.wdata == $past(i_cmd.pc_next)) else $error("call push wrong");
    AST_RET_PC: assert property (o_mem.rd && o_mem.word && i_mem_ack
        |=> o_resp.done && o_resp.pc_load && o_resp.pc == $past(i_mem_rdata))
        else $error("return address wrong");
    CV_MEM_BIT: cover property (take && i_cmd.mem_op && i_cmd.op <= bmb_pkg::inv_carry_to_bit_op);
    CV_PUSH: cover property (o_mem.wr && o_mem.word && i_mem_ack);
    CV_TAKEN: cover property (o_resp.done && o_resp.pc_load);
endmodule
bind bmb_unit bmb_unit_props u_bmb_unit_props (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .o_ready(o_ready), .o_resp(o_resp),
    .o_mem(o_mem), .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata), .o_flags(o_flags),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata));
`default_nettype wire

// ---- bench/tb_top.sv ----
// self-checking bench: random bit ops, branches, calls, register port
// assumes bmb_mem_model on the memory port and the bound checker
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk, i_resetn, i_cmd_valid, i_mem_ack, i_reg_wr, i_reg_rd, o_ready, slow;
    bmb_pkg::bmb_cmd_t i_cmd;
    bmb_pkg::bmb_resp_t o_resp;
    bmb_pkg::bmb_mem_req_t o_mem;
    logic [31:0] i_mem_rdata, i_reg_wdata, o_reg_rdata;
    logic [31:0] seed = 32'h13d2; // fixed seed for repeatable runs
    logic [3:0] o_flags;
    logic [1:0] i_reg_addr;
    int miscompares = 0;
    int check_count = 0;
    always #10 i_clk = ~i_clk; // 50 MHz
    bmb_unit u_bmb_unit (.i_clk(i_clk), .i_resetn(i_resetn), .i_cmd_valid(i_cmd_valid),
        .i_cmd(i_cmd), .o_ready(o_ready), .o_resp(o_resp), .o_mem(o_mem), .i_mem_ack(i_mem_ack),
        .i_mem_rdata(i_mem_rdata), .o_flags(o_flags), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .o_reg_rdata(o_reg_rdata));
    bmb_mem_model u_bmb_mem_model (.i_clk(i_clk), .i_resetn(i_resetn), .i_mem(o_mem),
        .i_slow(slow), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // expected {zero, carry, write-back, byte} of one bit instruction
    function automatic logic [10:0] bit_exp(input bmb_pkg::bmb_op_t op, input logic [7:0] b,
        input logic [2:0] p, input logic [3:0] f);
        logic c, z, x;
        logic [7:0] n;
        {c, z, x, n} = {f[0], f[2], b[p], b};
        case (op)
            bmb_pkg::bit_set_op: n[p] = 1'b1;
            bmb_pkg::bit_clear_op: n[p] = 1'b0;
            bmb_pkg::bit_invert_op: n[p] = ~x;
            bmb_pkg::bit_test_op: z = ~x;
            bmb_pkg::carry_and_bit_op: c = c & x;
            bmb_pkg::carry_and_inv_bit_op: c = c & ~x;
            bmb_pkg::carry_or_bit_op: c = c | x;
            bmb_pkg::carry_or_inv_bit_op: c = c | ~x;
            bmb_pkg::carry_xor_bit_op: c = c ^ x;
            bmb_pkg::carry_xor_inv_bit_op: c = c ^ ~x;
            bmb_pkg::bit_to_carry_op: c = x;
            bmb_pkg::inv_bit_to_carry_op: c = ~x;
            bmb_pkg::carry_to_bit_op: n[p] = c;
            default: n[p] = ~c;
        endcase
        return {z, c, op <= bmb_pkg::bit_invert_op || op >= bmb_pkg::carry_to_bit_op, n};
    endfunction
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one register write, or a read compared in the cycle after the strobe
    task automatic reg_acc(input logic w, input logic [1:0] a, input logic [31:0] d);
        @(posedge i_clk);
        {i_reg_addr, i_reg_wdata, i_reg_wr, i_reg_rd} <= {a, d, w, !w};
        @(posedge i_clk);
        {i_reg_wr, i_reg_rd} <= 2'b00;
        if (!w) begin
            @(negedge i_clk);
            chk(o_reg_rdata, d);
            @(negedge i_clk);
            chk(o_reg_rdata, 32'h0);
        end
    endtask
    // offer one instruction while idle, then wait for done with a bound
    task automatic run(input bmb_pkg::bmb_cmd_t c);
        int i;
        @(posedge i_clk);
        {i_cmd, i_cmd_valid} <= {c, 1'b1};
        @(posedge i_clk);
        i_cmd_valid <= 1'b0;
        for (i = 0; i < 40; i++) begin
            @(negedge i_clk);
            if (o_resp.done === 1'b1) break;
        end
        if (i == 40) begin
            miscompares++;
            end_sim();
        end
        chk(32'(o_ready), 32'h1);
    endtask
    initial begin
        bmb_pkg::bmb_cmd_t c;
        logic [31:0] r, sp, link [2];
        logic [10:0] e;
        logic [7:0] v, t;
        logic [3:0] f;
        logic [2:0] p;
        {i_clk, i_resetn, i_cmd_valid, i_reg_wr, i_reg_rd, slow} = '0;
        {i_cmd, i_reg_addr, i_reg_wdata} = '0;
        sp = bmb_pkg::SP_RESET;
        repeat (10) @(posedge i_clk);
        i_resetn <= 1'b1;
        reg_acc(0, bmb_pkg::REG_FLAGS, 32'h0);
        reg_acc(0, bmb_pkg::REG_SP, sp);
        reg_acc(1, bmb_pkg::REG_STATUS, '1);
        reg_acc(1, 2'h3, '1);
        reg_acc(0, bmb_pkg::REG_STATUS, 32'h0);
        reg_acc(0, 2'h3, 32'h0);
        $display("test registers done");
        // every bit op once first, then random ops, operands and bit sources
        for (int k = 0; k < 150; k++) begin
            r = rnd();
            f = r[3:0];
            reg_acc(1, bmb_pkg::REG_FLAGS, 32'(f));
            r = rnd();
            c = '0;
            c.op = bmb_pkg::bmb_op_t'(k < 14 ? k : r[3:0] % 14);
            {c.mem_op, c.bit_from_reg, c.bit_imm, c.bit_reg, c.reg_data} = r[24:4];
            c.addr = 32'(r[30:25]);
            slow = r[31];
            v = c.mem_op ? u_bmb_mem_model.mem_b[c.addr[7:0]] : c.reg_data;
            p = (c.bit_from_reg && c.op <= bmb_pkg::bit_test_op) ? c.bit_reg[2:0] : c.bit_imm;
            e = bit_exp(c.op, v, p, f);
            run(c);
            chk(32'(o_flags), 32'({f[3], e[10], f[1], e[9]}));
            if (c.mem_op) chk(32'(u_bmb_mem_model.mem_b[c.addr[7:0]]), 32'(e[7:0]));
            if (!c.mem_op) chk(32'(o_resp.reg_we), 32'(e[8]));
            if (!c.mem_op && e[8]) chk(32'(o_resp.reg_data), 32'(e[7:0]));
        end
        $display("test bit ops done");
        for (int k = 0; k < 32; k++) begin
            f = 4'(rnd());
            reg_acc(1, bmb_pkg::REG_FLAGS, 32'(f));
            c = '0;
            c.op = bmb_pkg::cond_branch_op;
            c.cond = 4'(k);
            c.target = rnd();
            t = {f[2] | (f[3] ^ f[1]), f[3] ^ f[1], f[3], f[1], f[2], f[0], f[0] | f[2], 1'b0};
            run(c);
            chk(32'(o_resp.pc_load), 32'(t[c.cond[3:1]] == c.cond[0]));
            if (t[c.cond[3:1]] == c.cond[0]) chk(o_resp.pc, c.target);
            reg_acc(0, bmb_pkg::REG_STATUS, {30'h0, t[c.cond[3:1]] == c.cond[0], 1'b0});
        end
        $display("test branches done");
        c.op = bmb_pkg::unconditional_jump_op;
        run(c);
        chk(o_resp.pc, c.target);
        chk(32'(o_resp.pc_load), 32'h1);
        reg_acc(0, bmb_pkg::REG_SP, sp);
        for (int k = 0; k < 2; k++) begin
            c.op = k ? bmb_pkg::relative_call_op : bmb_pkg::absolute_call_op;
            c.target = rnd();
            c.pc_next = rnd();
            slow = c.target[0];
            run(c);
            chk(o_resp.pc, k ? c.pc_next + c.target : c.target);
            sp -= bmb_pkg::STACK_STEP;
            chk(u_bmb_mem_model.mem_w[sp[7:0]], c.pc_next);
            link[k] = c.pc_next;
        end
        reg_acc(0, bmb_pkg::REG_SP, sp);
        for (int k = 1; k >= 0; k--) begin
            c.op = bmb_pkg::return_op;
            run(c);
            chk(o_resp.pc, link[k]);
            sp += bmb_pkg::STACK_STEP;
        end
        reg_acc(0, bmb_pkg::REG_SP, sp);
        $display("test calls done");
        end_sim();
    end
endmodule
`default_nettype wire
